/* logic/version_array_page_add.v */
// execution engine for the add-version-array leaf, with apb register access
// assumes pclk 10 MHz, zero-wait apb master, and an external page writer
// that accepts one 32-bit word per cycle on mem_wr_en
//
// Behaviour
// - leaf value 0x0a in leaf select starts the version-array creation flow
// - page type operand not version-array type gives general protection fault, code 0
// - target address not 4 KB aligned gives general protection fault, code 0
// - target outside the protected page cache gives page fault with the address
// - another enclave operation on the target page gives general protection fault
// - target map entry already valid gives page fault; only free pages qualify
// - on success every bit 32767..0 of the page is written to zero
// - on success map entry becomes version-array type, fields cleared, valid set
// - target address is data segment base plus the address operand only
// - protected mode: operand beyond data segment limit gives general protection fault
// - 64-bit mode: non-canonical operand gives general protection fault, code 0
// - translation fault on the operand is reported as page fault with its code
// - the target page is written, so the engine drives page writes and locks it
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "va_page_add_defines.vh"

module version_array_page_add (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire        other_op_active,
  input  wire [3:0]  other_op_index,
  input  wire        xlate_fault,
  input  wire [15:0] xlate_fault_code,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         mem_wr_en,
  output reg  [31:0] mem_wr_addr,
  output reg  [31:0] mem_wr_data,
  output reg         page_lock,
  output reg  [3:0]  page_lock_index
);

  // ************************************************************
  // states
  // ************************************************************
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_CHECK = 4'b0010;
  localparam [3:0] ST_CLEAR = 4'b0100;
  localparam [3:0] ST_DONE  = 4'b1000;

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg  [7:0]  leaf_select;
  reg  [31:0] page_type_op;
  reg  [31:0] addr_op;
  reg  [31:0] addr_op_hi;
  reg  [31:0] seg_base;
  reg  [31:0] seg_limit;
  reg  [1:0]  mode;
  reg  [31:0] arith_flags;
  reg  [31:0] result_reg;
  reg  [31:0] cache_base;
  reg  [3:0]  map_index;
  reg         done_flag;
  reg         bad_leaf;
  reg  [1:0]  fault_kind;
  reg  [15:0] fault_code;
  reg  [31:0] fault_addr;
  reg  [31:0] target_addr;
  reg  [3:0]  target_index;
  reg  [9:0]  word_cnt;
  reg  [1:0]  next_fault;
  reg  [15:0] next_code;
  wire        wr_xfer;
  wire        busy;
  wire [31:0] lin_addr;
  wire [31:0] cache_ofs;
  wire        resident;
  wire [3:0]  lin_index;
  wire        canonical;
  wire        commit;
  wire [15:0] ent_valid;
  wire [255:0] attr_flat;
  wire [511:0] lin_flat;
  wire [15:0] sel_attr;
  wire [31:0] sel_lin;
  wire        map_sw_wr;
  wire        map_sw_lin_wr;
  wire [31:0] status_word;

  // ************************************************************
  // address formation and checks
  // ************************************************************
  // only the data segment is used; no override path exists
  assign lin_addr  = seg_base + addr_op;
  assign cache_ofs = lin_addr - cache_base;
  // 16 pages of 4 KB span 64 KB above the cache base
  assign resident  = (cache_ofs[31:16] == 16'h0000);
  // the page index is the 4 KB frame within the cache window
  assign lin_index = cache_ofs[15:12];
  // bits 63..47 all equal; operand high word holds bits 63..32
  assign canonical = (addr_op_hi[31:15] == 17'h00000) ||
                     (addr_op_hi[31:15] == 17'h1ffff);
  // engine state and the write strobe seen by the register file
  assign busy      = ~state[0];
  assign wr_xfer   = psel & penable & pready & pwrite;
  // last clear word and entry update share one edge
  assign commit    = state[2] && (word_cnt == `PAGE_WORDS_LAST);
  // indexed views of the map for software readback
  assign sel_attr  = attr_flat[map_index*16 +: 16];
  assign sel_lin   = lin_flat[map_index*32 +: 32];
  // software may seed map entries only while the engine is idle
  assign map_sw_wr     = wr_xfer & ~busy & (paddr == `OFS_MAP_ATTR);
  assign map_sw_lin_wr = wr_xfer & ~busy & (paddr == `OFS_MAP_LINEAR);

  // status word as software reads it; busy is live, the rest is latched
  assign status_word   = {fault_code, 11'h000, bad_leaf, fault_kind, done_flag, busy};

  // fault decision, first failing check wins
  // the translation fault is looked at only in the check cycle, so a
  // fault that clears before then is never reported
  always @* begin
    next_fault = `FAULT_NONE;
    next_code  = 16'h0000;
    if (mode[`MODE_PROT_BIT] && !mode[`MODE_LONG_BIT] && (addr_op > seg_limit)) begin
      next_fault = `FAULT_GP;
    end else if (mode[`MODE_LONG_BIT] && !canonical) begin
      next_fault = `FAULT_GP;
    end else if (page_type_op != {24'h000000, `VA_PAGE_TYPE}) begin
      next_fault = `FAULT_GP;
    end else if (lin_addr[11:0] != 12'h000) begin
      next_fault = `FAULT_GP;
    end else if (xlate_fault) begin
      next_fault = `FAULT_PF;
      next_code  = xlate_fault_code;
    end else if (!resident) begin
      next_fault = `FAULT_PF;
    end else if (other_op_active && (other_op_index == lin_index)) begin
      next_fault = `FAULT_GP;
    end else if (ent_valid[lin_index]) begin
      next_fault = `FAULT_PF;
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  // next state
  always @* begin
    case (state)
      ST_IDLE: begin
        if (wr_xfer && (paddr == `OFS_LEAF_SELECT) && (pwdata[7:0] == `LEAF_ADD_VA))
          next_state = ST_CHECK;
        else
          next_state = ST_IDLE;
      end
      // the whole check list resolves in a single cycle
      ST_CHECK: begin
        if (next_fault == `FAULT_NONE)
          next_state = ST_CLEAR;
        else
          next_state = ST_DONE;
      end
      // one word per cycle, 1024 cycles for the page
      ST_CLEAR: begin
        if (word_cnt == `PAGE_WORDS_LAST)
          next_state = ST_DONE;
        else
          next_state = ST_CLEAR;
      end
      ST_DONE:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  // state, page clearing and outcome capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_IDLE;
      word_cnt        <= 10'h000;
      target_addr     <= `RST_WORD;
      target_index    <= 4'h0;
      fault_kind      <= `FAULT_NONE;
      fault_code      <= 16'h0000;
      fault_addr      <= `RST_WORD;
      done_flag       <= 1'b0;
      bad_leaf        <= 1'b0;
      mem_wr_en       <= 1'b0;
      mem_wr_addr     <= `RST_WORD;
      mem_wr_data     <= `RST_WORD;
      page_lock       <= 1'b0;
      page_lock_index <= 4'h0;
    end else begin
      state <= next_state;
      // a new leaf write clears the previous outcome
      if (state[0] && wr_xfer && (paddr == `OFS_LEAF_SELECT)) begin
        done_flag  <= 1'b0;
        fault_kind <= `FAULT_NONE;
        fault_code <= 16'h0000;
        bad_leaf   <= (pwdata[7:0] != `LEAF_ADD_VA);
      end
      // latch the target and the outcome of the checks
      if (state[1]) begin
        target_addr  <= lin_addr;
        target_index <= lin_index;
        word_cnt     <= 10'h000;
        fault_kind   <= next_fault;
        fault_code   <= next_code;
        if (next_fault == `FAULT_PF)
          fault_addr <= lin_addr;
        if (next_fault == `FAULT_NONE) begin
          // hold the page against other operations while it is written
          page_lock       <= 1'b1;
          page_lock_index <= lin_index;
          mem_wr_en       <= 1'b1;
          mem_wr_addr     <= lin_addr;
        end
      end
      // one zero word per cycle; the writer has no back-pressure,
      // so a writer that stalls would lose words
      if (state[2]) begin
        word_cnt    <= word_cnt + 10'h001;
        mem_wr_addr <= mem_wr_addr + 32'h00000004;
        if (word_cnt == `PAGE_WORDS_LAST)
          mem_wr_en <= 1'b0;
      end
      // outcome published and page released in the same cycle
      if (state[3]) begin
        done_flag <= 1'b1;
        page_lock <= 1'b0;
      end
    end
  end

  // ************************************************************
  // page map entries
  // ************************************************************
  // one slice per cache page; engine commit beats software seeding,
  // though seeding cannot happen while busy anyway
  genvar gi;
  generate
    for (gi = 0; gi < `CACHE_PAGES; gi = gi + 1) begin : g_entry
      reg [15:0] attr;
      reg [31:0] lin;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          attr <= `RST_ATTR;
          lin  <= `RST_WORD;
        end else if (commit && (target_index == gi)) begin
          // type set, linear address, entry_bit_a, pending, modified,
          // restriction and permissions cleared, valid set
          attr <= {`VA_PAGE_TYPE, 8'h01};
          lin  <= `RST_WORD;
        end else begin
          if (map_sw_wr && (map_index == gi))
            attr <= pwdata[15:0];
          if (map_sw_lin_wr && (map_index == gi))
            lin <= pwdata;
        end
      end
      // flattened so the readback mux and the checks can index by page
      assign ent_valid[gi]           = attr[`ATTR_VALID_BIT];
      assign attr_flat[gi*16 +: 16]  = attr;
      assign lin_flat[gi*32 +: 32]   = lin;
    end
  endgenerate

  // ************************************************************
  // apb register file
  // ************************************************************
  // flags and result are plain storage that the operation never writes,
  // so software finds them as it left them
  // operand and configuration registers; frozen while busy so a running
  // check sees stable operands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      leaf_select  <= 8'h00;
      page_type_op <= `RST_WORD;
      addr_op      <= `RST_WORD;
      addr_op_hi   <= `RST_WORD;
      seg_base     <= `RST_WORD;
      seg_limit    <= `RST_WORD;
      mode         <= 2'h0;
      arith_flags  <= `RST_WORD;
      result_reg   <= `RST_WORD;
      cache_base   <= `RST_WORD;
      map_index    <= 4'h0;
    end else if (wr_xfer && !busy) begin
      case (paddr)
        `OFS_LEAF_SELECT:  leaf_select  <= pwdata[7:0];
        `OFS_PAGE_TYPE_OP: page_type_op <= pwdata;
        `OFS_ADDR_OP:      addr_op      <= pwdata;
        `OFS_ADDR_OP_HI:   addr_op_hi   <= pwdata;
        `OFS_SEG_BASE:     seg_base     <= pwdata;
        `OFS_SEG_LIMIT:    seg_limit    <= pwdata;
        `OFS_MODE:         mode         <= pwdata[1:0];
        `OFS_ARITH_FLAGS:  arith_flags  <= pwdata;
        `OFS_RESULT:       result_reg   <= pwdata;
        `OFS_CACHE_BASE:   cache_base   <= pwdata;
        `OFS_MAP_INDEX:    map_index    <= pwdata[3:0];
        default:           map_index    <= map_index;
      endcase
    end
  end

  // bus answer: pready one cycle after setup, data and error registered
  // the slave never stretches a transfer beyond one access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
    end else begin
      pready  <= psel & ~pready;
      pslverr <= 1'b0;
      prdata  <= `RST_WORD;
      // read data latched in setup so it stands through the access cycle
      if (psel && !penable) begin
        case (paddr)
          `OFS_LEAF_SELECT:  prdata <= {24'h000000, leaf_select};
          `OFS_PAGE_TYPE_OP: prdata <= page_type_op;
          `OFS_ADDR_OP:      prdata <= addr_op;
          `OFS_ADDR_OP_HI:   prdata <= addr_op_hi;
          `OFS_SEG_BASE:     prdata <= seg_base;
          `OFS_SEG_LIMIT:    prdata <= seg_limit;
          `OFS_MODE:         prdata <= {30'h00000000, mode};
          `OFS_STATUS:       prdata <= status_word;
          `OFS_FAULT_ADDR:   prdata <= fault_addr;
          `OFS_ARITH_FLAGS:  prdata <= arith_flags;
          `OFS_RESULT:       prdata <= result_reg;
          `OFS_CACHE_BASE:   prdata <= cache_base;
          `OFS_MAP_INDEX:    prdata <= {28'h0000000, map_index};
          `OFS_MAP_ATTR:     prdata <= {16'h0000, sel_attr};
          `OFS_MAP_LINEAR:   prdata <= sel_lin;
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // version_array_page_add

/* shared/va_page_add_defines.vh */
// constants for the version-array page add engine
// assumes a 32-bit apb slave and a 16-page protected page cache
`ifndef VA_PAGE_ADD_DEFINES_VH
`define VA_PAGE_ADD_DEFINES_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFS_LEAF_SELECT   8'h00
`define OFS_PAGE_TYPE_OP  8'h04
`define OFS_ADDR_OP       8'h08
`define OFS_SEG_BASE      8'h0c
`define OFS_SEG_LIMIT     8'h10
`define OFS_MODE          8'h14
`define OFS_STATUS        8'h18
`define OFS_FAULT_ADDR    8'h1c
`define OFS_ARITH_FLAGS   8'h20
`define OFS_MAP_INDEX     8'h24
`define OFS_MAP_ATTR      8'h28
`define OFS_CACHE_BASE    8'h2c
`define OFS_ADDR_OP_HI    8'h30
`define OFS_MAP_LINEAR    8'h34
`define OFS_RESULT        8'h38

// ************************************************************
// operation constants
// ************************************************************
`define LEAF_ADD_VA       8'h0a
`define VA_PAGE_TYPE      8'h01
`define CACHE_PAGES       16
`define PAGE_WORDS_LAST   10'h3ff

// ************************************************************
// field positions
// ************************************************************
`define MODE_PROT_BIT     0
`define MODE_LONG_BIT     1
`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_KIND_LSB       2
`define ST_BADLEAF_BIT    4
`define ATTR_VALID_BIT    0
`define ATTR_ENTRY_BIT_A_BIT  1
`define ATTR_PENDING_BIT  2
`define ATTR_MODIFIED_BIT 3
`define ATTR_PR_BIT       4
`define ATTR_TYPE_LSB     8

// fault kinds
`define FAULT_NONE        2'h0
`define FAULT_GP          2'h1
`define FAULT_PF          2'h2

// ************************************************************
// reset values
// ************************************************************
`define RST_WORD          32'h00000000
`define RST_ATTR          16'h0000

`endif

/* testbench/vapa_asserts.sv */
// checker for the version-array page add engine
// sees only the engine's ports; attached by the bind at the foot
`timescale 1ns/100ps
module vapa_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        other_op_active,
  input wire [3:0]  other_op_index,
  input wire        xlate_fault,
  input wire        mem_wr_en,
  input wire [31:0] mem_wr_addr,
  input wire [31:0] mem_wr_data,
  input wire        page_lock,
  input wire [3:0]  page_lock_index
);
  // ****
  // helper: length of the current clear burst
  // ****
  logic [10:0] run;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) run <= 11'h0;
    else run <= mem_wr_en ? run + 11'h1 : 11'h0;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence burst_end_s; $fell(mem_wr_en) ##0 page_lock; endsequence

  a_apb_answer: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  a_zero_data: assert property (mem_wr_en |-> mem_wr_data == 32'h0)
    else $error("page written with nonzero data");
  a_addr_step: assert property (mem_wr_en && $past(mem_wr_en)
    |-> mem_wr_addr == $past(mem_wr_addr) + 32'h4) else $error("clear address step");
  a_burst_len: assert property ($fell(mem_wr_en) |-> run == 11'h400)
    else $error("clear burst not one page");
  a_page_base: assert property ($rose(mem_wr_en) |-> mem_wr_addr[11:0] == 12'h0)
    else $error("clear starts off a page base");
  a_lock_span: assert property (mem_wr_en |-> page_lock)
    else $error("page written without lock");
  a_free_to_go: assert property ($rose(mem_wr_en) |-> !$past(xlate_fault)
    && !($past(other_op_active) && $past(other_op_index) == page_lock_index))
    else $error("clear despite busy page or fault");
  a_lock_release: assert property (burst_end_s |=> !page_lock)
    else $error("lock held after commit");
  a_lock_hold: assert property (page_lock && $past(page_lock) |-> $stable(page_lock_index))
    else $error("locked index moved");
endmodule // vapa_asserts

bind version_array_page_add vapa_asserts vapa_asserts_inst (
  .pclk, .presetn, .psel, .penable, .pready, .other_op_active, .other_op_index,
  .xlate_fault, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .page_lock, .page_lock_index
);

/* testbench/version_array_page_add_tb.sv */
// testbench for the version-array page add engine
// drives apb and the side inputs itself; checker is bound from its own file
`timescale 1ns/100ps
`include "va_page_add_defines.vh"
module version_array_page_add_tb;
  // ****
  // signals and cases
  // ****
  logic        pclk, presetn, psel, penable, pwrite, other_op_active, xlate_fault, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, mem_wr_addr, mem_wr_data, rd;
  logic        pready, pslverr, mem_wr_en, page_lock;
  logic [3:0]  page_lock_index;
  logic [3:0]  other_op_index;
  int          fails, tests_run;
  typedef struct {logic [31:0] ty, lo, hi; logic [1:0] md; logic oth, xf; logic [31:0] st;} row_t;
  // type, address lo/hi, mode, other op, xlate fault, expected status
  row_t rows[12] = '{
    '{32'h1, 32'h10000, 32'h0, 2'h0, 1'b0, 1'b0, 32'h2},
    '{32'h1, 32'h10000, 32'h0, 2'h0, 1'b0, 1'b0, 32'ha},
    '{32'h2, 32'h11000, 32'h0, 2'h0, 1'b0, 1'b0, 32'h6},
    '{32'h1, 32'h11004, 32'h0, 2'h0, 1'b0, 1'b0, 32'h6},
    '{32'h1, 32'h30000, 32'h0, 2'h0, 1'b0, 1'b0, 32'ha},
    '{32'h1, 32'h12000, 32'h0, 2'h0, 1'b1, 1'b0, 32'h6},
    '{32'h1, 32'h12000, 32'h0, 2'h0, 1'b0, 1'b1, 32'hbeef000a},
    '{32'h1, 32'h13000, 32'h0, 2'h1, 1'b0, 1'b0, 32'h6},
    '{32'h1, 32'h13000, 32'h8000, 2'h2, 1'b0, 1'b0, 32'h6},
    '{32'h1, 32'h13000, 32'h0, 2'h2, 1'b0, 1'b0, 32'h2},
    '{32'h1, 32'h14000, 32'h0, 2'h0, 1'b1, 1'b0, 32'h2},        // other page busy
    '{32'h2, 32'h30000, 32'h0, 2'h0, 1'b0, 1'b0, 32'h6}};

  version_array_page_add version_array_page_add_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .other_op_active,
    .other_op_index, .xlate_fault, .xlate_fault_code(16'hbeef), .prdata, .pready,
    .pslverr, .mem_wr_en, .mem_wr_addr, .mem_wr_data, .page_lock, .page_lock_index);

  // ****
  // tasks
  // ****
  // one apb transfer; held until pready is seen at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for ready however long it takes; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out();
    $display("counts: %0d compared, %0d mismatched", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ****
  // clock, watchdog, sequence
  // ****
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // four page clears plus polling stay far below this
  initial begin
    #3000000;
    fails++;
    close_out();
  end
  initial begin
    {presetn, psel, penable, pwrite, other_op_active, xlate_fault} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    other_op_index = 4'h2;
    fails = 0;
    tests_run = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, `OFS_CACHE_BASE, 32'h10000, rd);
    apb(1'b1, `OFS_SEG_LIMIT, 32'h1000, rd);
    apb(1'b1, `OFS_ARITH_FLAGS, 32'h8d5, rd);
    apb(1'b1, `OFS_RESULT, 32'h1234, rd);
    foreach (rows[i]) begin
      apb(1'b1, `OFS_PAGE_TYPE_OP, rows[i].ty, rd);
      apb(1'b1, `OFS_ADDR_OP, rows[i].lo, rd);
      apb(1'b1, `OFS_ADDR_OP_HI, rows[i].hi, rd);
      apb(1'b1, `OFS_MODE, {30'h0, rows[i].md}, rd);
      other_op_active <= rows[i].oth;
      xlate_fault <= rows[i].xf;
      apb(1'b1, `OFS_LEAF_SELECT, {24'h0, `LEAF_ADD_VA}, rd);
      // write readback holds the old leaf, so clear it before polling
      rd = 32'h0;
      // poll until done; a clear takes about a thousand cycles
      for (int n = 0; n < 600 && rd[1] !== 1'b1; n++) apb(1'b0, `OFS_STATUS, 32'h0, rd);
      chk(rd, rows[i].st);
      if (rows[i].st[3:2] == 2'h2) begin
        apb(1'b0, `OFS_FAULT_ADDR, 32'h0, rd);
        chk(rd, rows[i].lo);
      end
      other_op_active <= 1'b0;
      xlate_fault <= 1'b0;
      $display("row %0d done", i);
    end
    // faulted rows must leave their entries free
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OFS_MAP_INDEX, 32'(i), rd);
      apb(1'b0, `OFS_MAP_ATTR, 32'h0, rd);
      chk(rd, (i == 0 || i == 3) ? 32'h101 : 32'h0);
      apb(1'b0, `OFS_MAP_LINEAR, 32'h0, rd);
      chk(rd, 32'h0);
    end
    // segment base is added to the operand before the alignment and cache checks
    apb(1'b1, `OFS_SEG_BASE, 32'h10000, rd);
    apb(1'b1, `OFS_PAGE_TYPE_OP, 32'h1, rd);
    apb(1'b1, `OFS_ADDR_OP, 32'h5000, rd);
    apb(1'b1, `OFS_MODE, 32'h0, rd);
    apb(1'b1, `OFS_LEAF_SELECT, {24'h0, `LEAF_ADD_VA}, rd);
    rd = 32'h0;
    for (int n = 0; n < 600 && rd[1] !== 1'b1; n++) apb(1'b0, `OFS_STATUS, 32'h0, rd);
    chk(rd, 32'h2);
    apb(1'b1, `OFS_MAP_INDEX, 32'h5, rd);
    apb(1'b0, `OFS_MAP_ATTR, 32'h0, rd);
    chk(rd, 32'h101);
    $display("segment base test done");
    apb(1'b0, `OFS_ARITH_FLAGS, 32'h0, rd);
    chk(rd, 32'h8d5);
    apb(1'b0, `OFS_RESULT, 32'h0, rd);
    chk(rd, 32'h1234);
    $display("map and flags test done");
    apb(1'b1, `OFS_LEAF_SELECT, 32'h3, rd);
    apb(1'b0, `OFS_STATUS, 32'h0, rd);
    chk(rd, 32'h10);
    apb(1'b0, 8'h3c, 32'h0, rd);
    chk({31'h0, err}, 32'h1);
    $display("bad leaf and unmapped test done");
    // reset while idle must free entry 0 again and clear the result
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `OFS_MAP_ATTR, 32'h0, rd);
    chk(rd, 32'h0);
    apb(1'b0, `OFS_RESULT, 32'h0, rd);
    chk(rd, 32'h0);
    $display("reset test done");
    close_out();
  end
endmodule // version_array_page_add_tb
